/* dv/ispc_port_chk.sv */
/*
  assertions on the port control block.
  assumes one clock domain, reset synchronous active low.
*/
`timescale 1ns/1ps
module ispc_port_chk #(
  parameter NSECT = 8
) (
  input wire             clk,
  input wire             nrst,
  input wire             cfgPinEnable,
  input wire             deviceBlank,
  input wire             logicTermPinSelect,
  input wire             secureBit,
  input wire [NSECT-1:0] primaryProtect,
  input wire [3:0]       secondProtect,
  input wire             regWrite,
  input wire [7:0]       regAddr,
  input wire [7:0]       regWdata,
  input wire [7:0]       regRdata,
  input wire             tdoOe,
  input wire             extStatusOut,
  input wire             extStatusOe,
  input wire             extErrorOut,
  input wire             extErrorOe,
  input wire             pinsForTest,
  input wire             extPinsForTest,
  input wire             flashBusy,
  input wire             secondWriting,
  input wire             flashFail,
  input wire             flashStart,
  input wire [2:0]       flashOp,
  input wire [1:0]       flashTarget,
  input wire [2:0]       flashSector,
  input wire             flashAbort,
  input wire             chipErased
);
  // ****
  // checks
  // ****
  reg [11:0] abortCnt;
  always @(posedge clk)
    if (!nrst) abortCnt <= 12'h000;
    else abortCnt <= flashAbort ? abortCnt + 12'h001 : 12'h000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  pin_enable_a: assert property (regAddr == 8'hC7 |-> pinsForTest ==
    (cfgPinEnable | deviceBlank | logicTermPinSelect | regRdata[0])) else $error("pin enable");
  pin_release_a: assert property (!pinsForTest |-> !tdoOe && !extStatusOe && !extErrorOe)
    else $error("pins driven while released");
  ext_gate_a: assert property (!extPinsForTest |-> !extStatusOe && !extErrorOe)
    else $error("extension pins driven");
  rten_write_a: assert property (regWrite && regAddr == 8'hC7 ##1 regAddr == 8'hC7
    |-> regRdata == {7'h00, $past(regWdata[0])}) else $error("enable bit write");
  rten_reset_a: assert property (disable iff (1'b0) !nrst |=>
    regAddr != 8'hC7 || regRdata == 8'h00) else $error("enable bit reset");
  secure_gate_a: assert property (flashStart && $past(secureBit) |-> flashOp == 3'h4)
    else $error("secured op started");
  protect_gate_a: assert property (flashStart && flashOp == 3'h2 |-> flashTarget[1] ||
    (flashTarget == 2'h0 && !primaryProtect[flashSector]) ||
    (flashTarget == 2'h1 && !secondProtect[flashSector[1:0]])) else $error("protected erase");
  status_busy_a: assert property ((flashBusy || secondWriting) [*2] ##0 extPinsForTest
    |-> !extStatusOut) else $error("status high while busy");
  error_latch_a: assert property (flashFail && extPinsForTest |=> !extErrorOut)
    else $error("error not flagged");
  chip_erase_a: assert property (chipErased |-> flashStart && flashOp == 3'h4)
    else $error("chip erase mark");
  abort_bound_a: assert property (abortCnt <= 12'h271) else $error("abort too long");
  abort_idle_a: assert property (flashAbort |-> !flashStart) else $error("start in abort");
  cover property (flashStart && flashOp == 3'h1);
  cover property (chipErased);
  cover property ($fell(flashAbort));
endmodule
bind ispc_port_ctrl ispc_port_chk #(.NSECT(NSECT)) chk (
  .clk(clk), .nrst(nrst), .cfgPinEnable(cfgPinEnable), .deviceBlank(deviceBlank),
  .logicTermPinSelect(logicTermPinSelect), .secureBit(secureBit),
  .primaryProtect(primaryProtect), .secondProtect(secondProtect), .regWrite(regWrite),
  .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .tdoOe(tdoOe),
  .extStatusOut(extStatusOut), .extStatusOe(extStatusOe), .extErrorOut(extErrorOut),
  .extErrorOe(extErrorOe), .pinsForTest(pinsForTest), .extPinsForTest(extPinsForTest),
  .flashBusy(flashBusy), .secondWriting(secondWriting), .flashFail(flashFail),
  .flashStart(flashStart), .flashOp(flashOp), .flashTarget(flashTarget),
  .flashSector(flashSector), .flashAbort(flashAbort), .chipErased(chipErased));

/* dv/ispc_port_ctrl_tb_top.sv */
/*
  testbench of the port control block with the controller model.
  assumes 25 MHz clk; bench drives inputs on the falling edge.
*/
`timescale 1ns/1ps
module ispc_port_ctrl_tb_top;
  reg        clk, nrst, cfgPinEnable, deviceBlank, logicTermPinSelect, secureBit, regWrite;
  reg        flashBusy, secondWriting, flashFail, sawChip;
  reg  [7:0] primaryProtect, regAddr, regWdata, sData;
  reg  [3:0] secondProtect;
  reg  [2:0] sOp;
  wire [7:0] regRdata, flashData;
  wire [2:0] flashOp, flashSector;
  wire [1:0] flashTarget;
  wire       tms, tck, tdi, tdoOut, tdoOe, extStatusOut, extStatusOe, extErrorOut, extErrorOe;
  wire       pinsForTest, extPinsForTest, flashStart, flashAbort, chipErased;
  integer    n_errors = 0, samples_checked = 0, nStarts = 0, n0, i;
  ispc_tester tester (.tms(tms), .tck(tck), .tdi(tdi));
  ispc_port_ctrl #(.NSECT(8)) dut (.clk(clk), .nrst(nrst), .cfgPinEnable(cfgPinEnable),
    .deviceBlank(deviceBlank), .logicTermPinSelect(logicTermPinSelect), .secureBit(secureBit),
    .primaryProtect(primaryProtect), .secondProtect(secondProtect), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .tmsPin(tms), .tckPin(tck),
    .tdiPin(tdi), .tdoOut(tdoOut), .tdoOe(tdoOe), .extStatusOut(extStatusOut),
    .extStatusOe(extStatusOe), .extErrorOut(extErrorOut), .extErrorOe(extErrorOe),
    .pinsForTest(pinsForTest), .extPinsForTest(extPinsForTest), .flashBusy(flashBusy),
    .secondWriting(secondWriting), .flashFail(flashFail), .flashStart(flashStart),
    .flashOp(flashOp), .flashTarget(flashTarget), .flashSector(flashSector),
    .flashData(flashData), .flashAbort(flashAbort), .chipErased(chipErased));
  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // start pulse lasts one clk, so a monitor catches it
  always @(posedge clk) if (flashStart) begin
    nStarts <= nStarts + 1;
    sOp <= flashOp;
    sData <= flashData;
  end
  always @(posedge clk) if (chipErased) sawChip <= 1'b1;
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      {regAddr, regWdata, regWrite} = {a, d, 1'b1};
      @(negedge clk);
      {regAddr, regWrite} = {8'hC7, 1'b0};
      #1;
    end
  endtask
  task opchk(input [7:0] ir, input [15:0] dr, input integer d);
    begin
      n0 = nStarts;
      tester.shift(1'b1, 8, {8'h00, ir});
      tester.shift(1'b0, 16, dr);
      chk(nStarts - n0, d);
      chk({tdoOe, tdoOut}, {1'b1, dr[0]});
    end
  endtask
  // ****
  // scenarios
  // ****
  task t_regs;
    begin
      wr(8'hC7, 8'h00);
      chk({regRdata, pinsForTest}, 9'h000);
      wr(8'hC7, 8'hFF);
      chk({regRdata, pinsForTest}, 9'h003);
      wr(8'h40, 8'h01);
      regAddr = 8'h40;
      #1 chk(regRdata, 8'h00);
      wr(8'hC7, 8'h00);
      chk(pinsForTest, 1'b0);
    end
  endtask
  task t_src;
    for (i = 0; i < 3; i = i + 1) begin
      @(negedge clk);
      {cfgPinEnable, deviceBlank, logicTermPinSelect} = 3'h1 << i;
      #1 chk(pinsForTest, 1'b1);
    end
  endtask
  task t_chan;
    begin
      tester.tap_reset;
      chk(tdoOe, 1'b0);
      tester.shift(1'b1, 8, 16'h0001);
      chk({tdoOe, extPinsForTest, extStatusOe}, 3'h4);
      tester.shift(1'b1, 8, 16'h0003);
      chk({extPinsForTest, extStatusOe}, 2'h2);
      @(negedge clk) flashBusy = 1'b1;
      repeat (3) @(negedge clk);
      chk({extStatusOe, extStatusOut}, 2'h2);
      flashBusy = 1'b0;
      tester.shift(1'b1, 8, 16'h0002);
      chk({extStatusOe, extStatusOut}, 2'h3);
      @(negedge clk) secondWriting = 1'b1;
      repeat (3) @(negedge clk);
      chk(extStatusOut, 1'b0);
      secondWriting = 1'b0;
    end
  endtask
  task t_ops;
    begin
      opchk(8'h11, 16'h10A5, 1);
      chk({sOp, sData}, 11'h1A5);
      chk({flashTarget, flashSector}, 5'h02);
      opchk(8'h11, 16'hC03C, 1);
      chk({flashTarget, flashSector}, 5'h18);
      opchk(8'h00, 16'h1800, 0);
      primaryProtect = 8'h04;
      secondProtect = 4'h1;
      opchk(8'h12, 16'h1000, 0);
      opchk(8'h12, 16'h4000, 0);
      opchk(8'h12, 16'h1800, 1);
      @(negedge clk) flashFail = 1'b1;
      @(negedge clk) flashFail = 1'b0;
      @(negedge clk) chk({extErrorOe, extErrorOut}, 2'h2);
      opchk(8'h05, 16'h0000, 0);
      chk(extErrorOut, 1'b1);
      secureBit = 1'b1;
      for (i = 16; i < 20; i = i + 1) opchk(i[7:0], 16'h1800, 0);
      opchk(8'h14, 16'h0000, 1);
      chk({sawChip, sOp}, 4'hC);
      secureBit = 1'b0;
    end
  endtask
  task t_abort;
    begin
      wr(8'hC7, 8'h01);
      @(negedge clk) {flashBusy, nrst} = 2'h2;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      #1 chk({flashAbort, regRdata}, 9'h100);
      flashBusy = 1'b0;
      // the abort must finish within 25 us
      for (i = 0; i < 700 && flashAbort; i = i + 1) @(negedge clk);
      chk(i <= 625, 1'b1);
    end
  endtask
  // error survives a plain reset, but not one that follows a disable
  task t_disarm;
    begin
      tester.tap_reset;
      tester.shift(1'b1, 8, 16'h0002);
      @(negedge clk) flashFail = 1'b1;
      @(negedge clk) flashFail = 1'b0;
      tester.shift(1'b1, 8, 16'h0004);
      chk({tdoOe, extPinsForTest}, 2'h0);
      @(negedge clk) nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      tester.tap_reset;
      tester.shift(1'b1, 8, 16'h0002);
      chk({extErrorOe, extErrorOut}, 2'h3);
    end
  endtask
  initial begin
    {nrst, cfgPinEnable, deviceBlank, logicTermPinSelect, secureBit, regWrite} = 6'h00;
    {flashBusy, secondWriting, flashFail, sawChip} = 4'h0;
    {primaryProtect, secondProtect, regAddr, regWdata} = 28'h000C700;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_regs;
    t_src;
    t_chan;
    t_ops;
    t_abort;
    t_disarm;
    wrap_up;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors = n_errors + 1;
    wrap_up;
  end
endmodule

/* dv/ispc_tester.sv */
/*
  model of the external programming controller: drives the test pins.
  assumes the port control samples tck with its own clock.
*/
`timescale 1ns/1ps
module ispc_tester #(
  parameter HALF = 160
) (
  output reg tms,
  output reg tck,
  output reg tdi
);
  // ****
  // link
  // ****
  initial begin
    tms = 1'b1;
    tck = 1'b0;
    tdi = 1'b0;
  end
  task bt(input t, input d);
    begin
      tms = t;
      tdi = d;
      #HALF tck = 1'b1;
      #HALF tck = 1'b0;
    end
  endtask
  // tck stands low between frames; tdi flips so a stale bit never passes
  task tap_reset;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) bt(1'b1, 1'b0);
      bt(1'b0, 1'b0);
      tdi = ~tdi;
    end
  endtask
  task shift(input ir, input integer n, input [15:0] v);
    integer i;
    begin
      bt(1'b1, 1'b0);
      if (ir) bt(1'b1, 1'b0);
      bt(1'b0, 1'b0);
      bt(1'b0, 1'b0);
      for (i = 0; i < n; i = i + 1) bt(i == n - 1, v[i]);
      bt(1'b1, 1'b0);
      bt(1'b0, 1'b0);
      tdi = ~tdi;
      #400;
    end
  endtask
endmodule

/* rtl/ispc_consts.vh */
/*
  constants for the in-system programming serial port control block.
  assumes a single 25 MHz clock and a test clock sampled as plain input.
*/
// Contract
// - pins enabled by config, register or term
// - pins inputs until enabling command arrives
// - disabled pins returned to general I/O
// - host sets run-time enable bit at C7h
// - enable bit cleared by reset or host
// - extension outputs driven only when requested
// - error low on fail until clear
// - status high in read, low busy
// - extension outputs selectable open-drain by command
// - secured device accepts only chip erase
// - chip erase clears security state
// - protected sectors are never erased; chip erase here is not gated by sector protection
// - programming commands only, no boundary scan
// - blank device enables pins by default
// - serial port programs arrays, logic, config
// - reset aborts cycle, read mode within 25us
// - product term should follow cable enable
// - status low while flash is busy
`ifndef ISPC_CONSTS_VH
`define ISPC_CONSTS_VH
// ****************************************
// register map
// ****************************************
`define ISPC_REG_RTEN      8'hC7
`define ISPC_RTEN_RESET    8'h00
`define ISPC_RTEN_BIT      0
`define ISPC_RTEN_RESET_BIT 1'b0
// ****************************************
// serial instruction codes (8-bit IR)
// ****************************************
`define ISPC_IR_W          8
`define ISPC_IR_ENABLE     8'h01
`define ISPC_IR_ENABLE_X   8'h02
`define ISPC_IR_ENABLE_XOD 8'h03
`define ISPC_IR_DISABLE    8'h04
`define ISPC_IR_CLRERR     8'h05
`define ISPC_IR_READ       8'h10
`define ISPC_IR_PROG       8'h11
`define ISPC_IR_SECTERASE  8'h12
`define ISPC_IR_VERIFY     8'h13
`define ISPC_IR_CHIPERASE  8'h14
`define ISPC_IR_BYPASS     8'hFF
// ****************************************
// data register layout (16 bits)
// ****************************************
`define ISPC_DR_W          16
`define ISPC_DR_TGT_HI     15
`define ISPC_DR_TGT_LO     14
`define ISPC_DR_SEC_HI     13
`define ISPC_DR_SEC_LO     11
`define ISPC_DR_DATA_HI    7
`define ISPC_DR_DATA_LO    0
`define ISPC_TGT_PRIMARY   2'h0
`define ISPC_TGT_SECOND    2'h1
`define ISPC_TGT_LOGIC     2'h2
`define ISPC_TGT_CONFIG    2'h3
// ****************************************
// timing
// ****************************************
`define ISPC_ABORT_US      25
`define ISPC_CLK_MHZ       25
`endif

/* rtl/ispc_port_ctrl.v */
/*
  serial programming port control: pin enable, extension outputs,
  security and sector protection gating, reset abort of flash cycles.
  assumes the flash core reports busy/fail and accepts one-cycle starts.
*/
`timescale 1ns/1ps
`include "ispc_consts.vh"
module ispc_port_ctrl #(
  parameter NSECT = 8
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             cfgPinEnable,
  input  wire             deviceBlank,
  input  wire             logicTermPinSelect,
  input  wire             secureBit,
  input  wire [NSECT-1:0] primaryProtect,
  input  wire [3:0]       secondProtect,
  input  wire             regWrite,
  input  wire [7:0]       regAddr,
  input  wire [7:0]       regWdata,
  output wire [7:0]       regRdata,
  input  wire             tmsPin,
  input  wire             tckPin,
  input  wire             tdiPin,
  output reg              tdoOut,
  output wire             tdoOe,
  output wire             extStatusOut,
  output wire             extStatusOe,
  output wire             extErrorOut,
  output wire             extErrorOe,
  output wire             pinsForTest,
  output wire             extPinsForTest,
  input  wire             flashBusy,
  input  wire             secondWriting,
  input  wire             flashFail,
  output reg              flashStart,
  output reg  [2:0]       flashOp,
  output reg  [1:0]       flashTarget,
  output reg  [2:0]       flashSector,
  output reg  [7:0]       flashData,
  output reg              flashAbort,
  output reg              chipErased
);
  localparam [2:0] OP_READ = 3'h0, OP_PROG = 3'h1, OP_SERASE = 3'h2;
  localparam [2:0] OP_VERIFY = 3'h3, OP_CERASE = 3'h4;
  localparam [3:0] T_RESET = 4'hF, T_CAPDR = 4'h6, T_SHDR = 4'h2, T_UPDR = 4'h5;
  localparam [3:0] T_CAPIR = 4'hE, T_SHIR = 4'hA, T_UPIR = 4'hD;
  localparam integer ABORT_INT = `ISPC_ABORT_US * `ISPC_CLK_MHZ;
  localparam [9:0]   ABORT_CYC = ABORT_INT[9:0];

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [2:0] syncA;
  reg [2:0] syncB;
  reg       tckPrev;
  always @(posedge clk) begin
    if (!nrst) begin
      syncA   <= 3'h0;
      syncB   <= 3'h0;
      tckPrev <= 1'b0;
    end else begin
      syncA   <= {tckPin, tmsPin, tdiPin};
      syncB   <= syncA;
      tckPrev <= syncB[2];
    end
  end
  wire tckRise = syncB[2] & ~tckPrev;
  wire tckFall = ~syncB[2] & tckPrev;
  wire tms     = syncB[1];
  wire tdi     = syncB[0];

  // ****************************************
  // run-time enable register
  // ****************************************
  reg rtEnable;
  always @(posedge clk) begin
    if (!nrst)
      rtEnable <= `ISPC_RTEN_RESET_BIT;
    else if (regWrite && regAddr == `ISPC_REG_RTEN)
      rtEnable <= regWdata[`ISPC_RTEN_BIT];
  end
  assign regRdata = (regAddr == `ISPC_REG_RTEN) ? {7'h00, rtEnable} : 8'h00;

  // ****************************************
  // combined pin enable
  // ****************************************
  // the term input is meant to follow the cable enable when pins are shared
  assign pinsForTest = cfgPinEnable | deviceBlank | rtEnable | logicTermPinSelect;

  // ****************************************
  // test-access controller
  // ****************************************
  wire [3:0] tapState;
  ispc_tap_fsm uTap (
    .clk     (clk),
    .nrst    (nrst),
    .tckRise (tckRise & pinsForTest),
    .tms     (tms),
    .state   (tapState)
  );

  reg [`ISPC_IR_W-1:0] irShift;
  reg [`ISPC_IR_W-1:0] ir;
  reg [`ISPC_DR_W-1:0] drShift;
  reg                  chanOn;
  reg                  extOn;
  reg                  extOd;
  reg                  errLatch;
  reg                  disArmed;

  function isProgCmd;
    input [`ISPC_IR_W-1:0] c;
    begin
      isProgCmd = (c == `ISPC_IR_READ) || (c == `ISPC_IR_PROG) ||
                  (c == `ISPC_IR_SECTERASE) || (c == `ISPC_IR_VERIFY) ||
                  (c == `ISPC_IR_CHIPERASE);
    end
  endfunction

  wire [1:0] tgt  = drShift[`ISPC_DR_TGT_HI:`ISPC_DR_TGT_LO];
  wire [2:0] sect = drShift[`ISPC_DR_SEC_HI:`ISPC_DR_SEC_LO];
  wire       protHit = (tgt == `ISPC_TGT_PRIMARY) ? primaryProtect[sect] :
                       (tgt == `ISPC_TGT_SECOND) ? secondProtect[sect[1:0]] : 1'b0;
  wire       upd     = tckRise && tapState == T_UPDR && chanOn;
  wire       allowed = isProgCmd(ir) &&
                       (!secureBit || ir == `ISPC_IR_CHIPERASE) &&
                       !(ir == `ISPC_IR_SECTERASE && protHit);

  // ****************************************
  // abort timer
  // ****************************************
  reg [9:0] abortCnt;
  always @(posedge clk) begin
    if (!nrst) begin
      // a reset in mid-cycle holds abort long enough for the core to unwind
      abortCnt   <= flashBusy ? ABORT_CYC : 10'h000;
      flashAbort <= flashBusy;
    end else begin
      abortCnt   <= (abortCnt != 10'h000) ? abortCnt - 10'h001 : 10'h000;
      flashAbort <= (abortCnt > 10'h001);
    end
  end

  // ****************************************
  // instruction and data paths
  // ****************************************
  always @(posedge clk) begin
    if (!nrst) begin
      irShift     <= 8'h00;
      ir          <= `ISPC_IR_BYPASS;
      drShift     <= 16'h0000;
      chanOn      <= 1'b0;
      extOn       <= 1'b0;
      extOd       <= 1'b0;
      disArmed    <= 1'b0;
      flashStart  <= 1'b0;
      flashOp     <= OP_READ;
      flashTarget <= `ISPC_TGT_PRIMARY;
      flashSector <= 3'h0;
      flashData   <= 8'h00;
      chipErased  <= 1'b0;
    end else begin
      flashStart <= 1'b0;
      chipErased <= 1'b0;
      if (!pinsForTest) begin
        chanOn <= 1'b0;
        extOn  <= 1'b0;
      end else if (tckRise) begin
        case (tapState)
          T_RESET: ir <= `ISPC_IR_BYPASS;
          T_CAPIR: irShift <= 8'h01;
          T_SHIR:  irShift <= {tdi, irShift[7:1]};
          T_UPIR: begin
            ir <= irShift;
            if (irShift == `ISPC_IR_ENABLE || irShift == `ISPC_IR_ENABLE_X ||
                irShift == `ISPC_IR_ENABLE_XOD) begin
              chanOn   <= 1'b1;
              extOn    <= irShift != `ISPC_IR_ENABLE;
              extOd    <= irShift == `ISPC_IR_ENABLE_XOD;
              disArmed <= 1'b0;
            end else if (irShift == `ISPC_IR_DISABLE && chanOn) begin
              chanOn   <= 1'b0;
              extOn    <= 1'b0;
              disArmed <= 1'b1;
            end
          end
          T_CAPDR: drShift <= {8'h00, 7'h00, ~flashBusy};
          T_SHDR:  drShift <= {tdi, drShift[15:1]};
          T_UPDR: begin
            // no new cycle while a reset abort is still unwinding the core
            if (upd && allowed && !flashBusy && !flashAbort) begin
              flashStart  <= 1'b1;
              flashTarget <= tgt;
              flashSector <= sect;
              flashData   <= drShift[`ISPC_DR_DATA_HI:`ISPC_DR_DATA_LO];
              flashOp     <= (ir == `ISPC_IR_PROG) ? OP_PROG :
                             (ir == `ISPC_IR_SECTERASE) ? OP_SERASE :
                             (ir == `ISPC_IR_VERIFY) ? OP_VERIFY :
                             (ir == `ISPC_IR_CHIPERASE) ? OP_CERASE : OP_READ;
              chipErased  <= ir == `ISPC_IR_CHIPERASE;
            end
          end
          default: drShift <= drShift;
        endcase
      end
    end
  end

  // ****************************************
  // serial output, changes on falling test clock
  // ****************************************
  always @(posedge clk) begin
    if (!nrst)
      tdoOut <= 1'b0;
    else if (tckFall)
      tdoOut <= (tapState == T_SHIR) ? irShift[0] : drShift[0];
  end
  assign tdoOe = pinsForTest & chanOn;

  // ****************************************
  // extension outputs
  // ****************************************
  // error latch: fail wins over a clear in the same cycle
  always @(posedge clk) begin
    if (!nrst)
      errLatch <= disArmed ? 1'b0 : errLatch;
    else if (flashFail)
      errLatch <= 1'b1;
    else if (upd && ir == `ISPC_IR_CLRERR)
      errLatch <= 1'b0;
  end
  wire statusLvl = ~(flashBusy | secondWriting | flashAbort);
  assign extPinsForTest = pinsForTest & extOn;
  assign extStatusOut   = extOd ? 1'b0 : statusLvl;
  assign extStatusOe    = extPinsForTest & (~extOd | ~statusLvl);
  assign extErrorOut    = extOd ? 1'b0 : ~errLatch;
  assign extErrorOe     = extPinsForTest & (~extOd | errLatch);
endmodule

/* rtl/ispc_tap_fsm.v */
/*
  test-access controller state machine, advanced on sampled test clock rises.
  assumes tckRise is a one-cycle pulse in the clk domain.
*/
`timescale 1ns/1ps
module ispc_tap_fsm (
  input  wire       clk,
  input  wire       nrst,
  input  wire       tckRise,
  input  wire       tms,
  output reg  [3:0] state
);
  // ****************************************
  // standard sixteen-state walk
  // ****************************************
  localparam RESET = 4'hF, IDLE = 4'hC, SELDR = 4'h7, CAPDR = 4'h6, SHDR = 4'h2,
             EX1DR = 4'h1, PSDR = 4'h3, EX2DR = 4'h0, UPDR = 4'h5, SELIR = 4'h4,
             CAPIR = 4'hE, SHIR = 4'hA, EX1IR = 4'h9, PSIR = 4'hB, EX2IR = 4'h8,
             UPIR = 4'hD;
  reg [3:0] next_state;
  always @* begin
    case (state)
      RESET:   next_state = tms ? RESET : IDLE;
      IDLE:    next_state = tms ? SELDR : IDLE;
      SELDR:   next_state = tms ? SELIR : CAPDR;
      CAPDR:   next_state = tms ? EX1DR : SHDR;
      SHDR:    next_state = tms ? EX1DR : SHDR;
      EX1DR:   next_state = tms ? UPDR  : PSDR;
      PSDR:    next_state = tms ? EX2DR : PSDR;
      EX2DR:   next_state = tms ? UPDR  : SHDR;
      UPDR:    next_state = tms ? SELDR : IDLE;
      SELIR:   next_state = tms ? RESET : CAPIR;
      CAPIR:   next_state = tms ? EX1IR : SHIR;
      SHIR:    next_state = tms ? EX1IR : SHIR;
      EX1IR:   next_state = tms ? UPIR  : PSIR;
      PSIR:    next_state = tms ? EX2IR : PSIR;
      EX2IR:   next_state = tms ? UPIR  : SHIR;
      UPIR:    next_state = tms ? SELDR : IDLE;
      default: next_state = RESET;
    endcase
  end
  always @(posedge clk) begin
    if (!nrst)
      state <= RESET;
    else if (tckRise)
      state <= next_state;
  end
endmodule
